// *** inc/ige_pkg.sv ***
// Package with the register map, field layouts and bus carriers of the block.
package ige_pkg;

    // Register byte offsets.
    localparam logic [11:0] OFS_IDENT     = 12'h008;
    localparam logic [11:0] OFS_GROUP     = 12'h080;
    localparam logic [11:0] OFS_EN_SET    = 12'h100;
    localparam logic [11:0] OFS_EN_CLR    = 12'h180;
    localparam logic [11:0] OFS_CFG       = 12'h010;
    localparam logic [11:0] OFS_ARRAY_SPAN = 12'h080;

    // Identification register field positions.
    localparam int ID_PART_LSB  = 24;
    localparam int ID_VAR_LSB   = 16;
    localparam int ID_REV_LSB   = 12;
    localparam int ID_CONT_LSB  = 8;

    // Configuration register fields: bit 0 locks group 0 shared lines.
    localparam int CFG_LOCK_BIT = 0;

    // Interrupts per register word and first shared identifier.
    localparam int IRQ_PER_WORD = 32;
    localparam int FIRST_SHARED = 32;

    // Reset values.
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // AXI4-Lite request and response carriers.
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic [2:0]  awprot;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic [2:0]  arprot;
        logic        rready;
    } ige_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ige_axi_rsp_t;

endpackage

// *** src/ige_regs.sv ***
// Group-select and forward-enable registers of an interrupt distributor.
// Function
// - Maker field: continuation code, zero bit 7, seven-bit identity code.
// - Variant and revision distinguish products only, not generations.
// - Group bit 0 means Group 0, 1 means Group 1.
// - With security, group registers are secure only; non-secure zero/ignored.
// - Bits of unimplemented interrupts read zero and ignore writes.
// - Lines count plus one registers per array, numbered up from zero.
// - Index zero banked per processor, holding interrupts 0 to 31.
// - On reset interrupts 32 and above are Group 0.
// - Group bit m at 0x080 plus four times m/32, bit m mod 32.
// - Enable-set bit m at 0x100 plus four times m/32.
// - First generation without security: group range reads zero.
// - Second generation without security: group resets all zero.
// - Optional: banked group bits of non-secure processors reset to one.
// - Writing one to enable-set enables forwarding; zero has no effect.
// - Enable-set reads one when forwarding enabled, else zero.
// - With security, Group 0 enable bits are zero/ignored to non-secure.
// - Lockdown may freeze group and enable bits of locked shared lines.
// - Software-generated lines are enabled through bank zero bits.
// - Writing one to enable-clear disables forwarding; zero no effect.
// - Disabling forwarding does not stop state changes elsewhere.
// - Lines count N supports 32 times N plus one interrupts.
module ige_regs #(
    parameter int          NUM_CPUS   = 2,
    parameter logic [4:0]  LINES_CNT  = 5'h01,
    parameter bit          SECURITY   = 1'b1,
    parameter bit          GEN_TWO    = 1'b1,
    parameter logic [31:0] IMPL_MASK  = 32'hffff_ffff,
    parameter logic [7:0]  PART_ID    = 8'h5a, // Arbitrary value.
    parameter logic [3:0]  VARIANT    = 4'h1,  // Arbitrary value.
    parameter logic [3:0]  REVISION   = 4'h2,  // Arbitrary value.
    parameter logic [3:0]  MAKER_CONT = 4'h7,  // Arbitrary value.
    parameter logic [6:0]  MAKER_CODE = 7'h2d, // Arbitrary value.
    parameter logic [31:0] NS_CPU_MASK = 32'h0000_0000,
    parameter logic [31:0] LOCKABLE    = 32'h0000_0000,
    localparam int NW  = int'(LINES_CNT) + 1,
    localparam int NI  = 32 * NW,
    localparam int CW  = (NUM_CPUS > 1) ? $clog2(NUM_CPUS) : 1
) (
    input  wire logic                 clk_in,        // 10 MHz clock.
    input  wire logic                 reset_n_in,    // Sync reset, active low.
    input  wire ige_pkg::ige_axi_req_t axi_req_in,   // AXI4-Lite requests.
    input  wire logic [CW-1:0]        aw_cpu_in,     // Writing processor.
    input  wire logic [CW-1:0]        ar_cpu_in,     // Reading processor.
    output ige_pkg::ige_axi_rsp_t     axi_rsp_out,   // AXI4-Lite answers.
    output logic [NI-1:0]             group_out,     // Shared group bits.
    output logic [NI-1:0]             enable_out,    // Shared enable bits.
    output logic [32*NUM_CPUS-1:0]    bank_group_out,  // Banked group bits.
    output logic [32*NUM_CPUS-1:0]    bank_enable_out  // Banked enables.
);
    import ige_pkg::*;

    typedef struct packed {
        logic [NW-1:1][31:0]       grp;
        logic [NW-1:1][31:0]       en;
        logic [NUM_CPUS-1:0][31:0] bgrp;
        logic [NUM_CPUS-1:0][31:0] ben;
        logic                      lock;
        logic                      aw_hold;
        logic [11:0]               aw_addr;
        logic                      aw_sec;
        logic [CW-1:0]             aw_cpu;
        logic                      w_hold;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        ige_axi_rsp_t              rsp;
    } ige_state_t;

    ige_state_t st_ff;
    ige_state_t nxt_st;

    // Decodes an array word index; returns NW or more when out of range.
    function automatic int word_idx(input logic [11:0] a,
                                    input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        if (a < base || d >= OFS_ARRAY_SPAN || a[1:0] != 2'h0)
            return NW;
        return int'(d[11:2]);
    endfunction

    // Bits of word w that map to implemented interrupts.
    function automatic logic [31:0] impl_bits(input int w);
        if (w >= NW) return RST_ZERO;
        return (w == 0) ? IMPL_MASK : 32'hffff_ffff;
    endfunction

    // Reset value of a banked group word for processor c.
    function automatic logic [31:0] bank_grp_rst(input int c);
        if (SECURITY && NS_CPU_MASK[c])
            return IMPL_MASK;
        return RST_ZERO;
    endfunction

    // Group registers visible at all only in these configurations.
    localparam bit GRP_EXISTS = GEN_TWO || SECURITY;

    // Read data assembly for one word and one viewing processor.
    function automatic logic [31:0] read_word(input ige_state_t s,
                                              input logic [11:0] a,
                                              input logic sec,
                                              input int cpu);
        int          wg;
        int          we;
        logic [31:0] g;
        logic [31:0] e;
        wg = word_idx(a, OFS_GROUP);
        we = word_idx(a, OFS_EN_SET);
        if (we >= NW) we = word_idx(a, OFS_EN_CLR);
        if (a == OFS_IDENT)
            return {PART_ID, 4'h0, VARIANT, REVISION,
                    MAKER_CONT, 1'b0, MAKER_CODE};
        if (a == OFS_CFG)
            return {31'h0, s.lock};
        if (wg < NW) begin
            g = (wg == 0) ? s.bgrp[cpu] : s.grp[wg];
            if (!GRP_EXISTS || (SECURITY && !sec))
                return RST_ZERO;
            return g & impl_bits(wg);
        end
        if (we < NW) begin
            g = (we == 0) ? s.bgrp[cpu] : s.grp[we];
            e = (we == 0) ? s.ben[cpu] : s.en[we];
            e = e & impl_bits(we);
            if (SECURITY && !sec)
                e = e & g;
            return e;
        end
        return RST_ZERO;
    endfunction

    // Next-state logic: bus handshakes and register updates.
    always_comb begin
        logic        aw_ok;
        logic        w_ok;
        logic        do_wr;
        int          wi;
        logic [31:0] m;
        logic [31:0] d;
        logic [31:0] gcur;
        int          c;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        do_wr = 1'b0;
        wi    = 0;
        m     = RST_ZERO;
        d     = RST_ZERO;
        gcur  = RST_ZERO;
        c     = 0;
        nxt_st = st_ff;
        nxt_st.rsp.awready = 1'b0;
        nxt_st.rsp.wready  = 1'b0;
        nxt_st.rsp.arready = 1'b0;
        // Accept address and data independently, one write in flight.
        aw_ok = axi_req_in.awvalid && !st_ff.aw_hold && !st_ff.rsp.bvalid
                && !st_ff.rsp.awready;
        w_ok  = axi_req_in.wvalid && !st_ff.w_hold && !st_ff.rsp.bvalid
                && !st_ff.rsp.wready;
        if (st_ff.rsp.awready) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = axi_req_in.awaddr;
            nxt_st.aw_sec  = !axi_req_in.awprot[1];
            nxt_st.aw_cpu  = aw_cpu_in;
        end
        if (st_ff.rsp.wready) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_data = axi_req_in.wdata;
            nxt_st.w_strb = axi_req_in.wstrb;
        end
        nxt_st.rsp.awready = aw_ok;
        nxt_st.rsp.wready  = w_ok;
        do_wr = st_ff.aw_hold && st_ff.w_hold;
        if (do_wr) begin
            nxt_st.aw_hold     = 1'b0;
            nxt_st.w_hold      = 1'b0;
            nxt_st.rsp.bvalid  = 1'b1;
            nxt_st.rsp.bresp   = (st_ff.w_strb == 4'hf) ? RESP_OKAY
                                                         : RESP_SLVERR;
            c = int'(st_ff.aw_cpu);
            d = st_ff.w_data;
            if (st_ff.w_strb == 4'hf && st_ff.aw_addr == OFS_CFG &&
                st_ff.aw_sec)
                nxt_st.lock = d[CFG_LOCK_BIT];
            // Group words: secure only, implemented bits, lock honoured.
            wi = word_idx(st_ff.aw_addr, OFS_GROUP);
            if (st_ff.w_strb == 4'hf && wi < NW && GRP_EXISTS &&
                (!SECURITY || st_ff.aw_sec)) begin
                m = impl_bits(wi);
                if (wi == 0) begin
                    nxt_st.bgrp[c] = (st_ff.bgrp[c] & ~m) | (d & m);
                end else begin
                    if (st_ff.lock)
                        m = m & ~(LOCKABLE & ~st_ff.grp[wi]);
                    nxt_st.grp[wi] = (st_ff.grp[wi] & ~m) | (d & m);
                end
            end
            // Enable set and clear words share the masking.
            wi = word_idx(st_ff.aw_addr, OFS_EN_SET);
            if (wi >= NW)
                wi = word_idx(st_ff.aw_addr, OFS_EN_CLR);
            if (st_ff.w_strb == 4'hf && wi < NW) begin
                gcur = (wi == 0) ? st_ff.bgrp[c] : st_ff.grp[wi];
                m = impl_bits(wi) & d;
                if (SECURITY && !st_ff.aw_sec)
                    m = m & gcur;
                if (wi != 0 && st_ff.lock)
                    m = m & ~(LOCKABLE & ~gcur);
                if (st_ff.aw_addr < OFS_EN_CLR) begin
                    if (wi == 0)
                        nxt_st.ben[c] = st_ff.ben[c] | m;
                    else
                        nxt_st.en[wi] = st_ff.en[wi] | m;
                end else begin
                    if (wi == 0)
                        nxt_st.ben[c] = st_ff.ben[c] & ~m;
                    else
                        nxt_st.en[wi] = st_ff.en[wi] & ~m;
                end
            end
        end
        if (st_ff.rsp.bvalid && axi_req_in.bready)
            nxt_st.rsp.bvalid = 1'b0;
        // Reads answer one cycle after the address is taken.
        if (st_ff.rsp.arready) begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rresp  = RESP_OKAY;
            nxt_st.rsp.rdata  = read_word(st_ff, axi_req_in.araddr,
                                          !axi_req_in.arprot[1],
                                          int'(ar_cpu_in));
        end else if (st_ff.rsp.rvalid && axi_req_in.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        nxt_st.rsp.arready = axi_req_in.arvalid && !st_ff.rsp.rvalid &&
                             !st_ff.rsp.arready;
    end

    // Single state register; reset clears everything except non-secure banked groups.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_ff <= '0;
            for (int i = 0; i < NUM_CPUS; i++)
                st_ff.bgrp[i] <= bank_grp_rst(i);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs are flip-flops already; forwarding logic gates on enable.
    always_comb begin
        axi_rsp_out     = st_ff.rsp;
        group_out       = {st_ff.grp, RST_ZERO};
        enable_out      = {st_ff.en, RST_ZERO};
        bank_group_out  = st_ff.bgrp;
        bank_enable_out = st_ff.ben;
    end

    // Checks.
    property p_set_holds;
        @(posedge clk_in) disable iff (!reset_n_in)
        (NW > 1 && $rose(st_ff.en[NW-1][0])) |=> st_ff.en[NW-1][0]
            || $past(st_ff.aw_addr) >= OFS_EN_CLR;
    endproperty
    a_set_holds: assert property (p_set_holds)
        else $error("Enable bit dropped without a clear.");

    property p_bresp_once;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_ff.aw_hold && st_ff.w_hold) |=> axi_rsp_out.bvalid;
    endproperty
    a_bresp_once: assert property (p_bresp_once)
        else $error("Write response missing after address and data.");

    property p_read_lat;
        @(posedge clk_in) disable iff (!reset_n_in)
        axi_rsp_out.arready |=> axi_rsp_out.rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("Read data not one cycle after address.");

    property p_rvalid_hold;
        @(posedge clk_in) disable iff (!reset_n_in)
        (axi_rsp_out.rvalid && !axi_req_in.rready) |=>
            (axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata));
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("Read data changed before taken.");

    property p_low_shared_zero;
        @(posedge clk_in) disable iff (!reset_n_in)
        group_out[31:0] == 32'h0 && enable_out[31:0] == 32'h0;
    endproperty
    a_low_shared_zero: assert property (p_low_shared_zero)
        else $error("Shared vectors show banked range.");

    property p_reset_group;
        @(posedge clk_in) $rose(reset_n_in) |-> group_out == '0;
    endproperty
    a_reset_group: assert property (p_reset_group)
        else $error("Shared group bits not zero after reset.");

    property p_ident_read;
        @(posedge clk_in) disable iff (!reset_n_in)
        (axi_rsp_out.arready && axi_req_in.araddr == OFS_IDENT) |=>
            (axi_rsp_out.rdata[23:20] == 4'h0 &&
             axi_rsp_out.rdata[7] == 1'b0);
    endproperty
    a_ident_read: assert property (p_ident_read)
        else $error("Identification reserved bits not zero.");

    property p_ns_group_raz;
        @(posedge clk_in) disable iff (!reset_n_in)
        (SECURITY && axi_rsp_out.arready && axi_req_in.arprot[1] &&
         word_idx(axi_req_in.araddr, OFS_GROUP) < NW) |=>
            axi_rsp_out.rdata == 32'h0;
    endproperty
    a_ns_group_raz: assert property (p_ns_group_raz)
        else $error("Non-secure group read not zero.");

    c_write: cover property (@(posedge clk_in)
        axi_rsp_out.bvalid && axi_req_in.bready);
    c_read: cover property (@(posedge clk_in)
        axi_rsp_out.rvalid && axi_req_in.rready);
    c_enable: cover property (@(posedge clk_in) $rose(|enable_out));
endmodule

// *** tb/ige_cpu_model.sv ***
// Behavioural processor model issuing secure and non-secure register accesses.
module ige_cpu_model (
    input  wire ige_pkg::ige_axi_rsp_t rsp_in,     // Answers from the block.
    input  wire logic                  clk_in,     // Bus clock.
    output ige_pkg::ige_axi_req_t      req_out,    // Requests to the block.
    output logic [0:0]                 aw_cpu_out, // Writing processor.
    output logic [0:0]                 ar_cpu_out  // Reading processor.
);
    timeunit 1ns;
    timeprecision 1ns;
    import ige_pkg::*;

    // Idle bus at time zero so nothing is requested during reset.
    initial begin
        req_out = '0;
        aw_cpu_out = 1'b0;
        ar_cpu_out = 1'b0;
    end

    // Address and data go out together; each is dropped when taken and the
    // payload is then inverted so a stale value can never pass for a hold.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic ns,
                      input logic [0:0] c, output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_in);
        req_out.awvalid <= 1'b1;
        req_out.awaddr <= a;
        req_out.awprot <= {1'b0, ns, 1'b0};
        req_out.wvalid <= 1'b1;
        req_out.wdata <= d;
        req_out.wstrb <= s;
        req_out.bready <= 1'b1;
        aw_cpu_out <= c;
        while (!(aw_done && w_done)) begin
            @(posedge clk_in);
            if (!aw_done && rsp_in.awready) begin
                aw_done = 1'b1;
                req_out.awvalid <= 1'b0;
                req_out.awaddr <= ~a;
            end
            if (!w_done && rsp_in.wready) begin
                w_done = 1'b1;
                req_out.wvalid <= 1'b0;
                req_out.wdata <= ~d;
            end
        end
        while (!rsp_in.bvalid) @(posedge clk_in);
        resp = rsp_in.bresp;
        req_out.bready <= 1'b0;
    endtask

    // Read: the request stands until taken, rready until the answer comes.
    task automatic rd(input logic [11:0] a, input logic ns,
                      input logic [0:0] c, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge clk_in);
        req_out.arvalid <= 1'b1;
        req_out.araddr <= a;
        req_out.arprot <= {1'b0, ns, 1'b0};
        req_out.rready <= 1'b1;
        ar_cpu_out <= c;
        do @(posedge clk_in); while (!rsp_in.arready);
        req_out.arvalid <= 1'b0;
        req_out.araddr <= ~a;
        while (!rsp_in.rvalid) @(posedge clk_in);
        d = rsp_in.rdata;
        resp = rsp_in.rresp;
        req_out.rready <= 1'b0;
    endtask
endmodule

// *** tb/irq_distributor_group_enable_regs_tb.sv ***
// Self-checking bench for the group-select and forward-enable registers.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module irq_distributor_group_enable_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ige_pkg::*;

    // Identity values are arbitrary; implemented mask leaves holes on purpose.
    localparam logic [7:0]  PID  = 8'h3c;
    localparam logic [3:0]  VAR  = 4'h6;
    localparam logic [3:0]  REV  = 4'h9;
    localparam logic [3:0]  CONT = 4'hb;
    localparam logic [6:0]  CODE = 7'h15;
    localparam logic [31:0] IMPL = 32'h0000_ff0f;
    localparam logic [31:0] G1   = 32'ha5a5_0001;
    localparam logic [31:0] IDW  = {PID, 4'h0, VAR, REV, CONT, 1'b0, CODE};

    logic         clk_in = 1'b0;
    logic         reset_n_in = 1'b0;
    ige_axi_req_t req;
    ige_axi_rsp_t rsp;
    logic [0:0]   aw_cpu;
    logic [0:0]   ar_cpu;
    logic [63:0]  group_out;
    logic [63:0]  enable_out;
    logic [63:0]  bank_group_out;
    logic [63:0]  bank_enable_out;
    int           n_mismatch = 0;
    int           num_checks = 0;

    // Clock of 100 ns period.
    always #50 clk_in = ~clk_in;

    ige_regs #(.NUM_CPUS(2), .SECURITY(1'b1),
        .IMPL_MASK(IMPL), .PART_ID(PID), .VARIANT(VAR),
        .REVISION(REV), .MAKER_CONT(CONT), .MAKER_CODE(CODE),
        .NS_CPU_MASK(32'h0000_0002), .LOCKABLE(32'h0000_000f)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .axi_req_in(req),
        .aw_cpu_in(aw_cpu), .ar_cpu_in(ar_cpu), .axi_rsp_out(rsp),
        .group_out(group_out), .enable_out(enable_out),
        .bank_group_out(bank_group_out), .bank_enable_out(bank_enable_out));

    ige_cpu_model u_cpu (.rsp_in(rsp), .clk_in(clk_in), .req_out(req),
        .aw_cpu_out(aw_cpu), .ar_cpu_out(ar_cpu));

    // Word write expecting an OKAY answer.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic ns, input logic [0:0] c);
        logic [1:0] resp;
        u_cpu.wr(a, d, 4'hf, ns, c, resp);
        `CHK(resp, RESP_OKAY)
    endtask

    // Word read compared with an expected value.
    task automatic rd(input logic [11:0] a, input logic ns,
                      input logic [0:0] c, input logic [31:0] exp);
        logic [1:0]  resp;
        logic [31:0] d;
        u_cpu.rd(a, ns, c, d, resp);
        `CHK(resp, RESP_OKAY)
        `CHK(d, exp)
    endtask

    // Reset state and the identification word.
    task automatic s_reset;
        `CHK(group_out, 64'h0)
        `CHK(enable_out, 64'h0)
        `CHK(bank_group_out, {IMPL, 32'h0})
        rd(OFS_IDENT, 1'b0, 1'b0, IDW);
    endtask

    // Group bits: banking, holes, secure-only access.
    task automatic s_group;
        wr(12'h080, 32'hffff_ffff, 1'b0, 1'b0);
        rd(12'h080, 1'b0, 1'b0, IMPL);
        @(negedge clk_in);
        `CHK(bank_group_out, {IMPL, IMPL})
        rd(12'h080, 1'b1, 1'b0, 32'h0);
        wr(12'h084, 32'hffff_ffff, 1'b1, 1'b0);
        wr(12'h084, G1, 1'b0, 1'b1);
        rd(12'h084, 1'b0, 1'b0, G1);
        @(negedge clk_in);
        `CHK(group_out, {G1, 32'h0})
    endtask

    // Set and clear of enable bits, and a probe of the banked word.
    task automatic s_enable;
        wr(12'h104, 32'h0000_0003, 1'b0, 1'b0);
        wr(12'h104, 32'h0000_0000, 1'b0, 1'b0);
        rd(12'h104, 1'b0, 1'b0, 32'h0000_0003);
        wr(12'h184, 32'h0000_0001, 1'b0, 1'b0);
        rd(12'h104, 1'b0, 1'b0, 32'h0000_0002);
        @(negedge clk_in);
        `CHK(enable_out, {32'h0000_0002, 32'h0})
        wr(12'h100, 32'hffff_ffff, 1'b0, 1'b1);
        rd(12'h100, 1'b0, 1'b1, IMPL);
        `CHK(bank_enable_out, {IMPL, 32'h0})
    endtask

    // Non-secure view is limited to Group 1 enable bits.
    task automatic s_nonsec;
        wr(12'h104, 32'hffff_ffff, 1'b1, 1'b0);
        rd(12'h104, 1'b0, 1'b0, G1 | 32'h2);
        rd(12'h104, 1'b1, 1'b0, G1);
    endtask

    // Partial strobes, words past the last register and unmapped holes.
    task automatic s_errors;
        logic [1:0] resp;
        u_cpu.wr(12'h104, 32'h0000_0004, 4'h3, 1'b0, 1'b0, resp);
        `CHK(resp, RESP_SLVERR)
        rd(12'h104, 1'b0, 1'b0, G1 | 32'h2);
        wr(12'h088, 32'hffff_ffff, 1'b0, 1'b0);
        rd(12'h088, 1'b0, 1'b0, 32'h0);
        rd(12'h00c, 1'b0, 1'b0, 32'h0);
    endtask

    // Lockdown freezes lockable Group 0 lines only.
    task automatic s_lock;
        wr(OFS_CFG, 32'h0000_0001, 1'b0, 1'b0);
        rd(OFS_CFG, 1'b0, 1'b0, 32'h0000_0001);
        wr(12'h084, G1 | 32'h1e, 1'b0, 1'b0);
        rd(12'h084, 1'b0, 1'b0, G1 | 32'h10);
        wr(12'h104, 32'h0000_0014, 1'b0, 1'b0);
        rd(12'h104, 1'b0, 1'b0, G1 | 32'h12);
    endtask

    // Verdict and end of run.
    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence after 12 cycles of reset.
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(negedge clk_in);
        s_reset();
        s_group();
        s_enable();
        s_nonsec();
        s_errors();
        s_lock();
        end_sim();
    end

    // Watchdog well beyond the under two hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        end_sim();
    end
endmodule
